/* hdl/gchps_pkg.sv */
`default_nettype none
// ==========================================================
// Shared constants for global control and host port select
// ==========================================================
package gchps_pkg;

  // ==========================================================
  // Clock and reset timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 100;        // Core clock period, 10 MHz
  localparam int RST_MAX_NS = 2000;          // Longest hardware reset process
  // Longest time, so rounded down to whole cycles
  localparam int RST_MAX_CYCLES = RST_MAX_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;            // Flip-flops in each pin synchroniser
  // Pin sync, FSM entry and output register eat into the budget
  localparam int RST_MARGIN_CYCLES = SYNC_STAGES + 2;
  localparam int RST_CNT_W = 5;              // Wide enough for the release count
  localparam logic [RST_CNT_W-1:0] RST_RELEASE_LAST =
    RST_CNT_W'(RST_MAX_CYCLES - RST_MARGIN_CYCLES - 1);
  localparam logic [RST_CNT_W-1:0] RST_CNT_RST = 5'h00;

  // ==========================================================
  // Default sizes
  // ==========================================================
  localparam int NUM_CHANNELS = 17;          // Line channels
  localparam int NUM_IRQ_SRC = 8;            // Interrupt sources
  localparam int GPIO_W = 2;                 // General purpose pins
  localparam int GCFG_W = 8;                 // Global configuration register width

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int GPIO_DIR_LSB = 0;           // Direction bits b1~0
  localparam int GPIO_LEVEL_LSB = 2;         // Level bits b3~2
  localparam int GPIO_REG_W = 4;
  localparam int INT_PIN_LSB = 2;            // Interrupt pin field b3~2
  localparam int INT_PIN_PP_BIT = 1;         // Field bit: 1 push-pull, 0 open drain
  localparam int INT_PIN_HIGH_BIT = 0;       // Field bit: 1 active high, 0 active low

  // ==========================================================
  // Values after reset
  // ==========================================================
  localparam logic PULLUP_OPEN = 1'b1;       // An open pulled-up strap reads high
  localparam logic RST_PIN_IDLE = 1'b1;      // Reset pin released
  localparam logic CS_IDLE = 1'b1;           // Chip select deasserted
  localparam logic OE_PIN_RST = 1'b0;        // Drivers off until the pin is seen

  // Device reset sequencer states
  typedef enum logic [1:0] {
    GCHPS_RST_HOLD = 2'b00,                  // Reset pin held low
    GCHPS_RST_RELEASE = 2'b01,               // Finishing the internal reset
    GCHPS_RST_RUN = 2'b10                    // Normal operation
  } gchps_rst_state_t;

endpackage
`default_nettype wire

/* hdl/gchps_gpio_if.sv */
`default_nettype none
// ==========================================================
// General purpose pin control bundle
// ==========================================================
interface gchps_gpio_if #(
  parameter int W = 2
);
  logic [W-1:0] dir;       // 1 output, 0 input
  logic [W-1:0] level_wr;  // Level to drive when output
  logic [W-1:0] pin_in;    // Synchronised pin level
  logic [W-1:0] level_rd;  // Level seen by software
  logic [W-1:0] pin_out;   // Level driven on the pin
  logic [W-1:0] pin_oe_n;  // Low while the pin is driven

  // Pin logic side
  modport pin (
    input dir, level_wr, pin_in,
    output level_rd, pin_out, pin_oe_n
  );
  // Control side
  modport ctl (
    output dir, level_wr, pin_in,
    input level_rd, pin_out, pin_oe_n
  );
endinterface
`default_nettype wire

/* hdl/gchps_sync.sv */
`default_nettype none
// ==========================================================
// Two flip-flop synchroniser for pin levels
// ==========================================================
module gchps_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // Both stages in one state word
  typedef struct packed {
    logic [W-1:0] s1;  // Metastable stage, read only by s2
    logic [W-1:0] s2;  // Settled stage
  } gchps_sync_state_t;

  gchps_sync_state_t st_r;
  gchps_sync_state_t st_nxt;

  // Shift pin level through both stages
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  // Reset to the pin's idle level
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule
`default_nettype wire

/* hdl/gchps_gpio.sv */
`default_nettype none
// ==========================================================
// General purpose pins: direction and level
// ==========================================================
module gchps_gpio
  import gchps_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic dev_rst_i,
  gchps_gpio_if.pin gp
);
  // Registered pin drive and readback
  typedef struct packed {
    logic [GPIO_W-1:0] level_rd;
    logic [GPIO_W-1:0] pin_out;
    logic [GPIO_W-1:0] pin_oe_n;
  } gchps_gpio_state_t;

  gchps_gpio_state_t st_r;
  gchps_gpio_state_t st_nxt;

  // Per pin: drive or sense by its own direction bit
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < GPIO_W; i++) begin
      st_nxt.pin_oe_n[i] = ~gp.dir[i] | dev_rst_i;
      st_nxt.pin_out[i] = gp.level_wr[i];
      // Output pins read back their driven level
      st_nxt.level_rd[i] = gp.dir[i] ? gp.level_wr[i] : gp.pin_in[i];
    end
  end

  // Pins float as inputs after reset
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '{level_rd: '0, pin_out: '0, pin_oe_n: '1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gp.level_rd = st_r.level_rd;
  assign gp.pin_out = st_r.pin_out;
  assign gp.pin_oe_n = st_r.pin_oe_n;
endmodule
`default_nettype wire

/* hdl/gchps_top.sv */
`default_nettype none
// ==========================================================
// Global control and host port select
// ==========================================================

// Notes on behaviour
// - Drivers enabled by pin, else all off
// - Pin gates only drivers, nothing else
// - Enable open: pin picks standard globally
// - Low means E1, open T1/J1
// - Each general pin has direction bit
// - Level bits report input, drive output
// - Low reset pulse, done within 2 us
// - Interrupt pin ORs unmasked pending sources
// - Config field picks drive and polarity
// - Host access only while select low
// - Ground serial port, supply parallel port
// - Each port uses its own pin group
// - Bus style: ground strobe, open separate
// - Multiplex select: ground plain, open muxed
module gchps_top
  import gchps_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS,
  parameter int NIRQ = NUM_IRQ_SRC
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Device pins
  input wire logic rst_pin_n_i,
  input wire logic line_drv_oe_pin_i,
  input wire logic hw_line_std_select_enable_i,
  input wire logic hw_line_std_select_i,
  input wire logic cs_n_i,
  input wire logic port_type_select_i,
  input wire logic parallel_bus_style_select_i,
  input wire logic bus_multiplex_select_i,
  input wire logic [GPIO_W-1:0] gpio_pin_i,
  output logic [GPIO_W-1:0] gpio_pin_o,
  output logic [GPIO_W-1:0] gpio_pin_oe_n_o,
  output logic int_pin_o,
  output logic int_pin_oe_n_o,
  // Register side, same clock
  input wire logic [NCH-1:0] channel_line_std_bit_i,
  input wire logic [NCH-1:0] line_drv_req_i,
  input wire logic [GPIO_REG_W-1:0] gpio_reg_i,
  input wire logic [GCFG_W-1:0] global_config_reg_i,
  input wire logic [NIRQ-1:0] irq_pending_i,
  input wire logic [NIRQ-1:0] irq_mask_i,
  // Results
  output logic [NCH-1:0] line_drv_en_o,
  output logic [NCH-1:0] line_std_t1_o,
  output logic [GPIO_W-1:0] gpio_level_o,
  output logic irq_active_o,
  output logic dev_rst_o,
  output logic host_access_en_o,
  output logic host_access_start_o,
  output logic serial_port_sel_o,
  output logic parallel_port_sel_o,
  output logic par_separate_strobes_o,
  output logic par_multiplexed_o
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  localparam int NPIN = 8;  // Single-bit pins grouped below

  logic [NPIN-1:0] pins_raw;  // Raw pin levels
  logic [NPIN-1:0] pins_s;    // Synchronised pin levels
  logic [GPIO_W-1:0] gpio_s;  // Synchronised general pins

  // Bit order of the grouped pins
  localparam int P_RST = 0;
  localparam int P_OE = 1;
  localparam int P_HWE = 2;
  localparam int P_HW = 3;
  localparam int P_CS = 4;
  localparam int P_PORT = 5;
  localparam int P_STYLE = 6;
  localparam int P_MUX = 7;

  assign pins_raw = {bus_multiplex_select_i, parallel_bus_style_select_i, port_type_select_i, cs_n_i,
                     hw_line_std_select_i, hw_line_std_select_enable_i, line_drv_oe_pin_i, rst_pin_n_i};

  localparam logic [NPIN-1:0] PIN_IDLE = {PULLUP_OPEN, PULLUP_OPEN, 1'b0, CS_IDLE,
                                          PULLUP_OPEN, PULLUP_OPEN, OE_PIN_RST, RST_PIN_IDLE};

  // Every pin crosses two flops before use
  gchps_sync #(
    .W(NPIN),
    .RST_VAL(PIN_IDLE)
  ) u_sync_pins (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  // General pins cross separately
  gchps_sync #(
    .W(GPIO_W),
    .RST_VAL('0)
  ) u_sync_gpio (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(gpio_pin_i),
    .q_o(gpio_s)
  );

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    gchps_rst_state_t rst_st;        // Reset sequencer
    logic [RST_CNT_W-1:0] rst_cnt;   // Release count
    logic cs_prev;                   // Select seen last cycle
    logic strap_parallel;            // Latched port type
    logic strap_sep_strobes;         // Latched bus style
    logic strap_muxed;               // Latched multiplex choice
    logic [NCH-1:0] drv_en;          // Line driver enables
    logic [NCH-1:0] std_t1;          // Line standard per channel
    logic irq_act;                   // Any unmasked source
    logic int_out;                   // Interrupt pin level
    logic int_oe_n;                  // Interrupt pin enable, low drives
    logic acc_en;                    // Host access window
    logic acc_start;                 // Access start pulse
  } gchps_top_state_t;

  gchps_top_state_t st_r;
  gchps_top_state_t st_nxt;

  logic in_reset;     // Internal reset still running
  logic int_pp;       // Push-pull interrupt pin
  logic int_act_high; // Interrupt asserted high
  logic int_level;    // Logical level for the pin

  assign in_reset = (st_r.rst_st != GCHPS_RST_RUN);
  assign int_pp = global_config_reg_i[INT_PIN_LSB + INT_PIN_PP_BIT];
  assign int_act_high = global_config_reg_i[INT_PIN_LSB + INT_PIN_HIGH_BIT];

  // ==========================================================
  // General pins
  // ==========================================================
  gchps_gpio_if #(.W(GPIO_W)) gp_if ();

  assign gp_if.dir = gpio_reg_i[GPIO_DIR_LSB +: GPIO_W];
  assign gp_if.level_wr = gpio_reg_i[GPIO_LEVEL_LSB +: GPIO_W];
  assign gp_if.pin_in = gpio_s;

  // Holds its pins released during the internal reset
  gchps_gpio u_gpio (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .dev_rst_i(in_reset),
    .gp(gp_if.pin)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    st_nxt = st_r;
    int_level = 1'b0;

    unique case (st_r.rst_st)
      GCHPS_RST_HOLD: begin
        // Wait for the pin to rise
        st_nxt.rst_cnt = RST_CNT_RST;
        if (pins_s[P_RST]) begin
          st_nxt.rst_st = GCHPS_RST_RELEASE;
        end
      end
      GCHPS_RST_RELEASE: begin
        // Fixed count keeps the whole process under the limit
        if (!pins_s[P_RST]) begin
          st_nxt.rst_st = GCHPS_RST_HOLD;
        end else if (st_r.rst_cnt == RST_RELEASE_LAST) begin
          st_nxt.rst_st = GCHPS_RST_RUN;
        end else begin
          st_nxt.rst_cnt = st_r.rst_cnt + 5'h01;
        end
      end
      GCHPS_RST_RUN: begin
        // A new low pulse restarts the reset sequence
        st_nxt.rst_cnt = RST_CNT_RST;
        if (!pins_s[P_RST]) begin
          st_nxt.rst_st = GCHPS_RST_HOLD;
        end
      end
      default: begin
        // Unused code falls back to holding
        st_nxt.rst_st = GCHPS_RST_HOLD;
        st_nxt.rst_cnt = RST_CNT_RST;
      end
    endcase

    // Straps are tied, so sample them only while in reset
    if (in_reset) begin
      st_nxt.strap_parallel = pins_s[P_PORT];
      st_nxt.strap_sep_strobes = pins_s[P_STYLE];
      st_nxt.strap_muxed = pins_s[P_MUX];
    end

    st_nxt.drv_en = pins_s[P_OE] ? line_drv_req_i : '0;

    if (pins_s[P_HWE]) begin
      st_nxt.std_t1 = {NCH{pins_s[P_HW]}};
    end else begin
      st_nxt.std_t1 = channel_line_std_bit_i;
    end

    st_nxt.irq_act = |(irq_pending_i & ~irq_mask_i) & ~in_reset;

    int_level = st_nxt.irq_act ~^ int_act_high;
    if (int_pp) begin
      // Push-pull: always driven
      st_nxt.int_out = int_level;
      st_nxt.int_oe_n = 1'b0;
    end else begin
      // Open drain: only ever pulls low
      st_nxt.int_out = 1'b0;
      st_nxt.int_oe_n = int_level;
    end

    st_nxt.cs_prev = pins_s[P_CS];
    st_nxt.acc_en = ~pins_s[P_CS] & ~in_reset;
    // each access opens with a falling select
    st_nxt.acc_start = st_r.cs_prev & ~pins_s[P_CS] & ~in_reset;
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // Power-up runs the same release count as a pin reset
      st_r.rst_st <= GCHPS_RST_RELEASE;
      st_r.rst_cnt <= RST_CNT_RST;
      st_r.cs_prev <= CS_IDLE;
      st_r.strap_parallel <= 1'b0;
      st_r.strap_sep_strobes <= PULLUP_OPEN;
      st_r.strap_muxed <= PULLUP_OPEN;
      st_r.drv_en <= '0;
      st_r.std_t1 <= '0;
      st_r.irq_act <= 1'b0;
      st_r.int_out <= 1'b0;
      st_r.int_oe_n <= 1'b1;
      st_r.acc_en <= 1'b0;
      st_r.acc_start <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign line_drv_en_o = st_r.drv_en;
  assign line_std_t1_o = st_r.std_t1;
  assign gpio_level_o = gp_if.level_rd;
  assign gpio_pin_o = gp_if.pin_out;
  assign gpio_pin_oe_n_o = gp_if.pin_oe_n;
  assign irq_active_o = st_r.irq_act;
  assign int_pin_o = st_r.int_out;
  assign int_pin_oe_n_o = st_r.int_oe_n;
  assign dev_rst_o = in_reset;
  assign host_access_en_o = st_r.acc_en;
  assign host_access_start_o = st_r.acc_start;

  assign serial_port_sel_o = ~st_r.strap_parallel;
  assign parallel_port_sel_o = st_r.strap_parallel;
  // Style choices mean nothing on the serial port
  assign par_separate_strobes_o = st_r.strap_parallel & st_r.strap_sep_strobes;
  assign par_multiplexed_o = st_r.strap_parallel & st_r.strap_muxed;

endmodule
`default_nettype wire

/* tb/gchps_top_props.sv */
`default_nettype none
// ==========================================================
// Checker on the top ports
// ==========================================================
module gchps_top_props
  import gchps_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS,
  parameter int NIRQ = NUM_IRQ_SRC
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic rst_pin_n_i,
  input wire logic line_drv_oe_pin_i,
  input wire logic hw_line_std_select_enable_i,
  input wire logic hw_line_std_select_i,
  input wire logic cs_n_i,
  input wire logic [GPIO_W-1:0] gpio_pin_i,
  input wire logic [GPIO_W-1:0] gpio_pin_o,
  input wire logic [GPIO_W-1:0] gpio_pin_oe_n_o,
  input wire logic int_pin_o,
  input wire logic int_pin_oe_n_o,
  input wire logic [NCH-1:0] channel_line_std_bit_i,
  input wire logic [NCH-1:0] line_drv_req_i,
  input wire logic [GPIO_REG_W-1:0] gpio_reg_i,
  input wire logic [GCFG_W-1:0] global_config_reg_i,
  input wire logic [NIRQ-1:0] irq_pending_i,
  input wire logic [NIRQ-1:0] irq_mask_i,
  input wire logic [NCH-1:0] line_drv_en_o,
  input wire logic [NCH-1:0] line_std_t1_o,
  input wire logic [GPIO_W-1:0] gpio_level_o,
  input wire logic irq_active_o,
  input wire logic dev_rst_o,
  input wire logic host_access_en_o,
  input wire logic host_access_start_o,
  input wire logic serial_port_sel_o,
  input wire logic parallel_port_sel_o,
  input wire logic par_separate_strobes_o,
  input wire logic par_multiplexed_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // ==========================================================
  // Line drivers and line standard
  // ==========================================================
  property p_drv_off;
    !line_drv_oe_pin_i[*3] |=> line_drv_en_o == '0;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("drivers not released");
  property p_drv_on;
    line_drv_oe_pin_i[*3] |=> line_drv_en_o == $past(line_drv_req_i);
  endproperty
  a_drv_on: assert property (p_drv_on) else $error("driver enable not from requests");
  property p_std_hw;
    (hw_line_std_select_enable_i && $stable(hw_line_std_select_i))[*3]
      |=> line_std_t1_o == {NCH{$past(hw_line_std_select_i)}};
  endproperty
  a_std_hw: assert property (p_std_hw) else $error("global standard wrong");
  property p_std_ch;
    !hw_line_std_select_enable_i[*3] |=> line_std_t1_o == $past(channel_line_std_bit_i);
  endproperty
  a_std_ch: assert property (p_std_ch) else $error("channel standard wrong");

  // ==========================================================
  // General pins
  // ==========================================================
  property p_gpio_out;
    gpio_reg_i[0] && !dev_rst_o |=> !gpio_pin_oe_n_o[0] && gpio_pin_o[0] == $past(gpio_reg_i[2]);
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("output pin level wrong");
  property p_gpio_in;
    (!dev_rst_o && !gpio_reg_i[1] && $stable(gpio_pin_i[1]))[*3] |=> gpio_level_o[1] == $past(gpio_pin_i[1]);
  endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("input pin readback wrong");

  // ==========================================================
  // Interrupt pin
  // ==========================================================
  property p_irq;
    1'b1 |=> irq_active_o == (!$past(dev_rst_o) && |($past(irq_pending_i) & ~$past(irq_mask_i)));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt summary wrong");
  property p_int_pp;
    global_config_reg_i[3] |=> !int_pin_oe_n_o && int_pin_o == (irq_active_o ~^ $past(global_config_reg_i[2]));
  endproperty
  a_int_pp: assert property (p_int_pp) else $error("push-pull pin wrong");
  property p_int_od;
    !global_config_reg_i[3] |=> int_pin_oe_n_o == (irq_active_o ~^ $past(global_config_reg_i[2]));
  endproperty
  a_int_od: assert property (p_int_od) else $error("open drain pin wrong");

  // ==========================================================
  // Host select, reset and straps
  // ==========================================================
  property p_acc_start;
    (!dev_rst_o && $fell(cs_n_i)) ##1 (!cs_n_i && !dev_rst_o)[*2] |=> host_access_start_o ##1 !host_access_start_o;
  endproperty
  a_acc_start: assert property (p_acc_start) else $error("access start pulse wrong");
  property p_acc_idle;
    cs_n_i[*3] |=> !host_access_en_o;
  endproperty
  a_acc_idle: assert property (p_acc_idle) else $error("access without select");
  property p_rst_in;
    !rst_pin_n_i[*3] |=> dev_rst_o ##1 gpio_pin_oe_n_o == '1;
  endproperty
  a_rst_in: assert property (p_rst_in) else $error("reset pin not obeyed");
  property p_rst_out;
    $rose(rst_pin_n_i) ##1 rst_pin_n_i[*8] |-> ##[0:12] !dev_rst_o;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset took too long");
  property p_port;
    !dev_rst_o |=> $stable({parallel_port_sel_o, par_separate_strobes_o, par_multiplexed_o});
  endproperty
  a_port: assert property (p_port) else $error("port select inconsistent");
endmodule

bind gchps_top gchps_top_props #(.NCH(NCH), .NIRQ(NIRQ)) u_props (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .rst_pin_n_i(rst_pin_n_i),
  .line_drv_oe_pin_i(line_drv_oe_pin_i), .hw_line_std_select_enable_i(hw_line_std_select_enable_i),
  .hw_line_std_select_i(hw_line_std_select_i), .cs_n_i(cs_n_i), .gpio_pin_i(gpio_pin_i),
  .gpio_pin_o(gpio_pin_o), .gpio_pin_oe_n_o(gpio_pin_oe_n_o), .int_pin_o(int_pin_o),
  .int_pin_oe_n_o(int_pin_oe_n_o), .channel_line_std_bit_i(channel_line_std_bit_i),
  .line_drv_req_i(line_drv_req_i), .gpio_reg_i(gpio_reg_i), .global_config_reg_i(global_config_reg_i),
  .irq_pending_i(irq_pending_i), .irq_mask_i(irq_mask_i), .line_drv_en_o(line_drv_en_o),
  .line_std_t1_o(line_std_t1_o), .gpio_level_o(gpio_level_o), .irq_active_o(irq_active_o),
  .dev_rst_o(dev_rst_o), .host_access_en_o(host_access_en_o), .host_access_start_o(host_access_start_o),
  .serial_port_sel_o(serial_port_sel_o), .parallel_port_sel_o(parallel_port_sel_o),
  .par_separate_strobes_o(par_separate_strobes_o), .par_multiplexed_o(par_multiplexed_o)
);
`default_nettype wire

/* tb/gchps_host_model.sv */
`default_nettype none
// ==========================================================
// Host processor: chip select and port straps
// ==========================================================
module gchps_host_model (
  output logic cs_n_o,
  output logic port_type_o,
  output logic bus_style_o,
  output logic bus_mux_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Parallel, style strap open, plain bus
  initial begin
    cs_n_o = 1'b1;
    port_type_o = 1'b1;
    bus_style_o = 1'b1;
    bus_mux_o = 1'b0;
  end
  task automatic cs_low();
    cs_n_o = 1'b0;
  endtask
  task automatic cs_high();
    cs_n_o = 1'b1;
  endtask
  task automatic set_straps(input logic par, input logic style, input logic mux);
    port_type_o = par;
    bus_style_o = par ? style : 1'b1;
    bus_mux_o = par ? mux : 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/gchps_top_tb.sv */
`default_nettype none
// ==========================================================
// Self-checking bench
// ==========================================================
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t ns: got %h expected %h", $time, got, exp); end end
module gchps_top_tb
  import gchps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NCH = NUM_CHANNELS;
  int n_tests = 0, n_mismatch = 0;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, rst_pin_n_i = 1'b1, line_drv_oe_pin_i = 1'b1;
  logic hw_en = 1'b1, hw_sel = 1'b1, cs_n, port_type, bus_style, bus_mux;
  logic [1:0] gpio_ext = 2'b11, gpio_wire, gpio_pin_o, gpio_pin_oe_n_o, gpio_level_o;
  logic int_pin_o, int_pin_oe_n_o, int_wire, irq_active_o, dev_rst_o, acc_en, acc_start;
  logic ser_sel, par_sel, sep_strobes, muxed;
  logic [NCH-1:0] ch_bits = '0, drv_req = '0, line_drv_en_o, line_std_t1_o;
  logic [3:0] gpio_reg_i = 4'h0;
  logic [7:0] gcfg = 8'h00, irq_pending_i = 8'h00, irq_mask_i = 8'hFF;

  // Clock, 100 ns period
  always #50 core_clk_i = ~core_clk_i;
  // Pin levels: driven side wins, else far side; interrupt line pulled up
  assign gpio_wire = (~gpio_pin_oe_n_o & gpio_pin_o) | (gpio_pin_oe_n_o & gpio_ext);
  assign int_wire = int_pin_oe_n_o | int_pin_o;

  gchps_host_model host (.cs_n_o(cs_n), .port_type_o(port_type), .bus_style_o(bus_style), .bus_mux_o(bus_mux));

  gchps_top dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .rst_pin_n_i(rst_pin_n_i),
    .line_drv_oe_pin_i(line_drv_oe_pin_i), .hw_line_std_select_enable_i(hw_en),
    .hw_line_std_select_i(hw_sel), .cs_n_i(cs_n), .port_type_select_i(port_type),
    .parallel_bus_style_select_i(bus_style), .bus_multiplex_select_i(bus_mux), .gpio_pin_i(gpio_wire),
    .gpio_pin_o(gpio_pin_o), .gpio_pin_oe_n_o(gpio_pin_oe_n_o), .int_pin_o(int_pin_o),
    .int_pin_oe_n_o(int_pin_oe_n_o), .channel_line_std_bit_i(ch_bits), .line_drv_req_i(drv_req),
    .gpio_reg_i(gpio_reg_i), .global_config_reg_i(gcfg), .irq_pending_i(irq_pending_i),
    .irq_mask_i(irq_mask_i), .line_drv_en_o(line_drv_en_o), .line_std_t1_o(line_std_t1_o),
    .gpio_level_o(gpio_level_o), .irq_active_o(irq_active_o), .dev_rst_o(dev_rst_o),
    .host_access_en_o(acc_en), .host_access_start_o(acc_start), .serial_port_sel_o(ser_sel),
    .parallel_port_sel_o(par_sel), .par_separate_strobes_o(sep_strobes), .par_multiplexed_o(muxed)
  );

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic step(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // Bounded wait for the internal reset to end
  task automatic wait_run(output int k);
    k = 0;
    while (dev_rst_o !== 1'b0 && k < 40) begin
      step(1);
      k++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far beyond the under two hundred cycles needed
  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_mismatch++;
    finish_test();
  end

  // ==========================================================
  // Tests
  // ==========================================================
  initial begin
    int k;
    logic lv;
    repeat (8) @(posedge core_clk_i);
    @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    wait_run(k);
    `CHK(dev_rst_o, 1'b0)
    `CHK({par_sel, sep_strobes, muxed}, 3'b110)
    // Driver gate, standard logic keeps working meanwhile
    drv_req = 17'h1A5C3;
    step(4);
    `CHK(line_drv_en_o, 17'h1A5C3)
    line_drv_oe_pin_i = 1'b0;
    hw_en = 1'b0;
    ch_bits = 17'h0F0F0;
    step(4);
    `CHK(line_drv_en_o, {NCH{1'b0}})
    `CHK(line_std_t1_o, 17'h0F0F0)
    line_drv_oe_pin_i = 1'b1;
    hw_en = 1'b1;
    hw_sel = 1'b0;
    step(4);
    `CHK(line_std_t1_o, {NCH{1'b0}})
    hw_sel = 1'b1;
    step(4);
    `CHK(line_std_t1_o, {NCH{1'b1}})
    hw_en = 1'b0;
    hw_sel = 1'b0;
    step(4);
    `CHK(line_std_t1_o, 17'h0F0F0)
    // Each pin in each direction, both levels
    for (int i = 0; i < 4; i++) begin
      gpio_reg_i = {i[0], i[0], i[1] ? 2'b10 : 2'b01};
      gpio_ext = {~i[0], ~i[0]};
      step(4);
      `CHK(gpio_pin_oe_n_o, i[1] ? 2'b01 : 2'b10)
      `CHK(gpio_wire[i[1]], i[0])
      `CHK(gpio_level_o[~i[1]], ~i[0])
    end
    // Every interrupt pin code, pending source masked or not
    irq_pending_i = 8'h81;
    for (int i = 0; i < 8; i++) begin
      gcfg = {4'h0, i[2:1], 2'b00};
      irq_mask_i = i[0] ? 8'h01 : 8'h81;
      lv = i[0] ~^ i[1];
      step(2);
      `CHK(irq_active_o, i[0])
      `CHK(int_wire, lv)
      `CHK(int_pin_oe_n_o, i[2] ? 1'b0 : lv)
    end
    // Host access window
    host.cs_low();
    step(3);
    `CHK(acc_start, 1'b1)
    step(1);
    `CHK({acc_start, acc_en}, 2'b01)
    step(2);
    host.cs_high();
    step(4);
    `CHK(acc_en, 1'b0)
    // Reset pulse with new straps; access refused meanwhile
    rst_pin_n_i = 1'b0;
    host.set_straps(1'b0, 1'b0, 1'b1);
    host.cs_low();
    step(4);
    `CHK(dev_rst_o, 1'b1)
    step(1);
    `CHK({gpio_pin_oe_n_o, acc_en}, 3'b110)
    host.cs_high();
    rst_pin_n_i = 1'b1;
    wait_run(k);
    `CHK(k <= RST_MAX_CYCLES, 1'b1)
    `CHK({ser_sel, par_sel, sep_strobes, muxed}, 4'b1000)
    host.set_straps(1'b1, 1'b0, 1'b1);
    step(4);
    `CHK({ser_sel, sep_strobes, muxed}, 3'b100)
    rst_pin_n_i = 1'b0;
    step(4);
    rst_pin_n_i = 1'b1;
    wait_run(k);
    `CHK({par_sel, sep_strobes, muxed}, 3'b101)
    finish_test();
  end
endmodule
`undef CHK
`default_nettype wire
